/* File: core/oag_adder.sv */
// Unsigned address adder registered on the output.
`timescale 1ns/1ps
module oag_adder
    import oag_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [15:0] base,
    input  wire logic [7:0]  index,
    input  wire logic        use_index,
    output logic      [15:0] sum_ff
);
    typedef struct packed {
        logic [15:0] sum;
    } oag_add_regs_t;

    oag_add_regs_t r_ff;
    oag_add_regs_t nxt_r;

    // Next sum; the carry out of the low byte reaches bit 8 and above.
    always_comb begin
        nxt_r     = r_ff;
        nxt_r.sum = base + (use_index ? {8'h00, index} : 16'h0000);
    end

    // Registered so that the effective address comes straight from flip-flops.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sum_ff = r_ff.sum;
endmodule

/* File: core/oag_core.sv */
// Operand address generator: fetches operand bytes and forms the effective address.
`timescale 1ns/1ps
module oag_core
    import oag_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        START,
    input  wire logic [3:0]  MODE,
    input  wire logic        INDIRECT,
    input  wire logic        MASK_RAISE_OP,
    input  wire logic        MASK_LOWER_OP,
    input  wire logic [7:0]  OPCODE,
    input  wire logic [7:0]  X_REG,
    input  wire logic [7:0]  Y_REG,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic        MEM_READY,
    output logic      [15:0] MEM_ADDR,
    output logic             MEM_RD,
    output logic      [15:0] EA,
    output logic      [7:0]  OPERAND,
    output logic      [2:0]  BIT_POS,
    output logic      [15:0] PC,
    output logic      [1:0]  INT_MASK,
    output logic             DONE
);
    typedef struct packed {
        oag_state_t  st;
        oag_mode_t   mode;
        logic        ind;
        logic        alt_y;
        logic        alt_ind_y;
        logic        op_long;
        logic [15:0] pc;
        logic [15:0] word;
        logic [7:0]  operand;
        logic [2:0]  bitpos;
        logic [1:0]  mask;
        logic        done;
        logic        use_idx;
        logic [15:0] base;
    } oag_regs_t;

    oag_regs_t   r_ff;
    oag_regs_t   nxt_r;
    logic [15:0] sum;
    logic        pfx_seen;

    // Adder sees the next base so its registered sum lines up with DONE.
    oag_adder u_add (
        .CLK       (CLK),
        .RST       (RST),
        .base      (nxt_r.base),
        .index     (nxt_r.alt_y ? Y_REG : X_REG),
        .use_index (nxt_r.use_idx),
        .sum_ff    (sum)
    );

    // Prefix bytes appear as the fetched opcode in the opcode state.
    assign pfx_seen = (MEM_RDATA == OAG_PFX_ALT_INDEX) || (MEM_RDATA == OAG_PFX_INDIRECT)
                      || (MEM_RDATA == OAG_PFX_ALT_INDIRECT);

    // Memory reads are issued from the fetch states only.
    always_comb begin
        MEM_RD   = (r_ff.st == OAG_S_OP1) || (r_ff.st == OAG_S_OP2)
                   || (r_ff.st == OAG_S_PTR1) || (r_ff.st == OAG_S_PTR2);
        MEM_ADDR = (r_ff.st == OAG_S_PTR1 || r_ff.st == OAG_S_PTR2) ? r_ff.word : r_ff.pc;
    end

    assign EA       = sum;
    assign OPERAND  = r_ff.operand;
    assign BIT_POS  = r_ff.bitpos;
    assign PC       = r_ff.pc;
    assign INT_MASK = r_ff.mask;
    assign DONE     = r_ff.done;

    // Sequencer: one read per cycle while MEM_READY is high.
    always_comb begin
        nxt_r      = r_ff;
        nxt_r.done = 1'b0;
        case (r_ff.st)
            OAG_S_OPC: begin
                if (START) begin
                    // The fetch stage has consumed the opcode; pc points past it.
                    nxt_r.mode      = oag_mode_t'(MODE);
                    nxt_r.ind       = INDIRECT || (pfx_seen && MEM_RDATA == OAG_PFX_INDIRECT);
                    nxt_r.alt_y     = (MEM_RDATA == OAG_PFX_ALT_INDEX) && pfx_seen;
                    nxt_r.alt_ind_y = (MEM_RDATA == OAG_PFX_ALT_INDIRECT) && pfx_seen;
                    nxt_r.bitpos    = OPCODE[3:1];
                    nxt_r.use_idx   = 1'b0;
                    nxt_r.word      = 16'h0000;
                    nxt_r.op_long   = (MODE == OAG_M_DIR_L) || (MODE == OAG_M_IDX_L);
                    if (nxt_r.alt_ind_y) begin
                        nxt_r.ind   = 1'b1;
                        nxt_r.alt_y = 1'b1;
                    end
                    if (MASK_RAISE_OP) begin
                        nxt_r.mask = OAG_MASK_RAISED;
                    end else if (MASK_LOWER_OP) begin
                        nxt_r.mask = OAG_MASK_LOWERED;
                    end
                    case (oag_mode_t'(MODE))
                        OAG_M_INH: begin
                            nxt_r.st   = OAG_S_DONE;
                        end
                        OAG_M_IDX_0: begin
                            nxt_r.use_idx = 1'b1;
                            nxt_r.base    = 16'h0000;
                            nxt_r.st      = nxt_r.ind ? OAG_S_OP1 : OAG_S_DONE;
                            nxt_r.done    = 1'b0;
                        end
                        default: begin
                            nxt_r.st = OAG_S_OP1;
                        end
                    endcase
                    if (nxt_r.st == OAG_S_DONE) begin
                        nxt_r.done = 1'b1;
                        nxt_r.st   = OAG_S_OPC;
                    end
                end
            end
            OAG_S_OP1: begin
                if (MEM_READY) begin
                    nxt_r.pc = r_ff.pc + 16'h0001;
                    if (r_ff.mode == OAG_M_IMM) begin
                        nxt_r.operand = MEM_RDATA;
                        nxt_r.done    = 1'b1;
                        nxt_r.st      = OAG_S_OPC;
                    end else if (r_ff.op_long && !r_ff.ind) begin
                        nxt_r.word = {MEM_RDATA, 8'h00};
                        nxt_r.st   = OAG_S_OP2;
                    end else if (r_ff.ind) begin
                        // Page-zero pointer address; pointer fetched next.
                        nxt_r.word = {8'h00, MEM_RDATA};
                        nxt_r.st   = OAG_S_PTR1;
                    end else if (r_ff.mode == OAG_M_REL) begin
                        nxt_r.operand = MEM_RDATA;
                        nxt_r.st      = OAG_S_REL;
                    end else begin
                        // Short direct, bit direct or short indexed: page-zero base.
                        nxt_r.base    = {8'h00, MEM_RDATA};
                        nxt_r.use_idx = (r_ff.mode == OAG_M_IDX_S);
                        nxt_r.done    = 1'b1;
                        nxt_r.st      = OAG_S_OPC;
                    end
                end
            end
            OAG_S_OP2: begin
                if (MEM_READY) begin
                    nxt_r.pc      = r_ff.pc + 16'h0001;
                    nxt_r.base    = {r_ff.word[15:8], MEM_RDATA};
                    nxt_r.use_idx = (r_ff.mode == OAG_M_IDX_L);
                    nxt_r.done    = 1'b1;
                    nxt_r.st      = OAG_S_OPC;
                end
            end
            OAG_S_PTR1: begin
                if (MEM_READY) begin
                    if (r_ff.mode == OAG_M_REL) begin
                        nxt_r.operand = MEM_RDATA;
                        nxt_r.st      = OAG_S_REL;
                    end else if (r_ff.op_long) begin
                        nxt_r.base = {MEM_RDATA, 8'h00};
                        nxt_r.word = r_ff.word + 16'h0001;
                        nxt_r.st   = OAG_S_PTR2;
                    end else begin
                        nxt_r.base    = {8'h00, MEM_RDATA};
                        nxt_r.use_idx = (r_ff.mode == OAG_M_IDX_S)
                                        || (r_ff.mode == OAG_M_IDX_0);
                        nxt_r.done    = 1'b1;
                        nxt_r.st      = OAG_S_OPC;
                    end
                end
            end
            OAG_S_PTR2: begin
                if (MEM_READY) begin
                    nxt_r.base    = {r_ff.base[15:8], MEM_RDATA};
                    nxt_r.use_idx = (r_ff.mode == OAG_M_IDX_L);
                    nxt_r.done    = 1'b1;
                    nxt_r.st      = OAG_S_OPC;
                end
            end
            OAG_S_REL: begin
                // Signed offset is sign extended before the add.
                nxt_r.pc   = r_ff.pc + {{8{r_ff.operand[7]}}, r_ff.operand};
                nxt_r.done = 1'b1;
                nxt_r.st   = OAG_S_OPC;
            end
            default: begin
                nxt_r.st = OAG_S_OPC;
            end
        endcase
    end

    // All sequencer state registered in one place; the EA sum register sits in oag_adder.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_ff      <= '0;
            r_ff.pc   <= OAG_RESET_PC;
            r_ff.mask <= OAG_RESET_MASK;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Raise instruction leaves mask at level three.
    mask_raise_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_OPC && START && MASK_RAISE_OP) |=> (INT_MASK == 2'h3))
        else $error("mask not raised");

    // Lower instruction leaves mask at level zero.
    mask_lower_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_OPC && START && MASK_LOWER_OP && !MASK_RAISE_OP) |=> (INT_MASK == 2'h0))
        else $error("mask not lowered");

    // Inherent finishes next cycle with no read.
    inherent_done_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_OPC && START && MODE == OAG_M_INH) |=> (DONE && !MEM_RD))
        else $error("inherent fetched bytes");

    // Immediate operand is the byte read.
    immediate_val_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_OP1 && MEM_READY && r_ff.mode == OAG_M_IMM)
        |=> (DONE && OPERAND == $past(MEM_RDATA)))
        else $error("immediate operand wrong");

    // Short direct address stays in page zero.
    short_direct_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_OP1 && MEM_READY && r_ff.mode == OAG_M_DIR_S && !r_ff.ind)
        |=> (EA == {8'h00, $past(MEM_RDATA)}))
        else $error("short direct address wrong");

    // Short indexed sum stays below 1ff.
    short_index_a: assert property (@(posedge CLK) disable iff (RST)
        (DONE && $past(r_ff.st) == OAG_S_OP1 && $past(r_ff.mode) == OAG_M_IDX_S
         && !$past(r_ff.ind)) |-> (EA <= 16'h01fe))
        else $error("short indexed out of range");

    // Long word takes its high byte first.
    long_order_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_OP1 && MEM_READY && r_ff.op_long && !r_ff.ind)
        |=> (r_ff.word[15:8] == $past(MEM_RDATA)))
        else $error("word byte order wrong");

    // Relative branch moves pc by the signed offset.
    rel_branch_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_REL)
        |=> (PC == $past(r_ff.pc) + {{8{$past(r_ff.operand[7])}}, $past(r_ff.operand)}))
        else $error("relative pc wrong");

    // The branch add needs no bus cycle, so a read here would be a stray request.
    rel_no_read_a: assert property (@(posedge CLK) disable iff (RST)
        (r_ff.st == OAG_S_REL) |-> !MEM_RD)
        else $error("read issued during branch");
endmodule

/* File: core/oag_pkg.sv */
// Package of constants and types for the operand address generator.
// Summary of operation
// - Inherent instruction is opcode only, no operands.
// - Immediate takes next byte as operand value.
// - Short direct fetches one byte page-zero address.
// - Long direct fetches two-byte full address.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed uses index register alone.
// - Short indexed adds byte offset, carries bit eight.
// - Long indexed adds word offset to index.
// - Short indirect reads byte pointer from page zero.
// - Long indirect reads word pointer from page zero.
// - Indirect indexed adds index to fetched pointer.
// - Short direct addressing reaches page zero only.
// - Mask raise instruction sets mask level three.
// - Mask lower instruction sets mask level zero.
// - Relative branch adds signed byte to PC.
// - Prefixes select Y index or indirect forms.
// - Alt indirect prefix makes indirect indexed use Y.
package oag_pkg;
    localparam logic [7:0] OAG_PFX_ALT_INDEX    = 8'h90;
    localparam logic [7:0] OAG_PFX_INDIRECT     = 8'h92;
    localparam logic [7:0] OAG_PFX_ALT_INDIRECT = 8'h91;
    localparam logic [1:0] OAG_MASK_RAISED      = 2'h3;
    localparam logic [1:0] OAG_MASK_LOWERED     = 2'h0;
    localparam logic [15:0] OAG_RESET_PC        = 16'h0000;
    localparam logic [1:0] OAG_RESET_MASK       = 2'h3;

    // Addressing modes as presented by the opcode map outside this block.
    typedef enum logic [3:0] {
        OAG_M_INH    = 4'h0,
        OAG_M_IMM    = 4'h1,
        OAG_M_DIR_S  = 4'h2,
        OAG_M_DIR_L  = 4'h3,
        OAG_M_IDX_0  = 4'h4,
        OAG_M_IDX_S  = 4'h5,
        OAG_M_IDX_L  = 4'h6,
        OAG_M_REL    = 4'h7,
        OAG_M_BIT    = 4'h8
    } oag_mode_t;

    typedef enum logic [3:0] {
        OAG_S_OPC    = 4'h0,
        OAG_S_OP1    = 4'h1,
        OAG_S_OP2    = 4'h2,
        OAG_S_PTR1   = 4'h3,
        OAG_S_PTR2   = 4'h4,
        OAG_S_REL    = 4'h5,
        OAG_S_DONE   = 4'h6
    } oag_state_t;
endpackage

/* File: verif/oag_mem_model.sv */
// Behavioural program and data memory that answers the address generator's reads.
`timescale 1ns/1ps
module oag_mem_model
    import oag_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic [3:0]  wait_cycles,
    output logic      [7:0]  mem_rdata,
    output logic             mem_ready
);
    logic [7:0] mem [0:65535];
    logic [3:0] cnt;

    // One ready pulse per read after a programmable wait; stale data is inverted every
    // cycle so that a read taken one cycle after the ready pulse never looks right by chance.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_ready <= 1'b0;
            mem_rdata <= 8'h00;
            cnt       <= 4'h0;
        end else if (mem_rd && !mem_ready && cnt == wait_cycles) begin
            mem_ready <= 1'b1;
            mem_rdata <= mem[mem_addr];
            cnt       <= 4'h0;
        end else begin
            mem_ready <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_rd && !mem_ready) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

/* File: verif/test_oag_core.sv */
// Self-checking testbench of the operand address generator.
`timescale 1ns/1ps
module test_oag_core
    import oag_pkg::*;
;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic        START = 1'b0;
    logic [3:0]  MODE = 4'h0;
    logic        INDIRECT = 1'b0;
    logic        MASK_RAISE_OP = 1'b0;
    logic        MASK_LOWER_OP = 1'b0;
    logic [7:0]  OPCODE = 8'h00;
    logic [7:0]  X_REG = 8'hff;
    logic [7:0]  Y_REG = 8'h40;
    logic [7:0]  MEM_RDATA;
    logic        MEM_READY;
    logic [15:0] MEM_ADDR;
    logic        MEM_RD;
    logic [15:0] EA;
    logic [7:0]  OPERAND;
    logic [2:0]  BIT_POS;
    logic [15:0] PC;
    logic [1:0]  INT_MASK;
    logic        DONE;
    logic [7:0]  mdl_rdata;
    logic [7:0]  pfx_q = 8'h00;
    logic [3:0]  wait_q = 4'h0;
    logic [15:0] pc_exp = 16'h0000;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;

    // The prefix byte reaches the core on the read data lines only while START is high.
    assign MEM_RDATA = START ? pfx_q : mdl_rdata;

    always #12.5 CLK = ~CLK;

    oag_core u_oag_core (.CLK(CLK), .RST(RST), .START(START), .MODE(MODE),
        .INDIRECT(INDIRECT), .MASK_RAISE_OP(MASK_RAISE_OP), .MASK_LOWER_OP(MASK_LOWER_OP),
        .OPCODE(OPCODE), .X_REG(X_REG), .Y_REG(Y_REG), .MEM_RDATA(MEM_RDATA),
        .MEM_READY(MEM_READY), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .EA(EA),
        .OPERAND(OPERAND), .BIT_POS(BIT_POS), .PC(PC), .INT_MASK(INT_MASK), .DONE(DONE));

    oag_mem_model u_oag_mem_model (.clk(CLK), .rst(RST), .mem_addr(MEM_ADDR),
        .mem_rd(MEM_RD), .wait_cycles(wait_q), .mem_rdata(mdl_rdata),
        .mem_ready(MEM_READY));

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares one value seen against the expected one.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Issues one instruction with its operand bytes at PC and waits for completion;
    // the PC advance tells whether exactly nb operand bytes were consumed.
    task automatic run(input oag_mode_t m, input logic ind, input logic [7:0] pfx,
                       input logic [7:0] opc, input logic [7:0] b0, input logic [7:0] b1,
                       input int nb, input logic rs, input logic lw);
        int i;
        u_oag_mem_model.mem[pc_exp] = b0;
        u_oag_mem_model.mem[pc_exp + 16'h1] = b1;
        @(posedge CLK);
        START <= 1'b1;
        MODE <= m;
        INDIRECT <= ind;
        pfx_q <= pfx;
        OPCODE <= opc;
        MASK_RAISE_OP <= rs;
        MASK_LOWER_OP <= lw;
        @(posedge CLK);
        START <= 1'b0;
        MASK_RAISE_OP <= 1'b0;
        MASK_LOWER_OP <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge CLK);
            if (DONE === 1'b1) break;
        end
        check({15'h0, DONE}, 16'h1);
        #1;
        pc_exp = pc_exp + nb[15:0];
        check(PC, pc_exp);
    endtask

    // Reset values of the visible state.
    task automatic t_reset();
        check({14'h0, INT_MASK}, {14'h0, OAG_RESET_MASK});
        check(PC, OAG_RESET_PC);
    endtask

    // Opcode-only instructions move the mask and consume no byte.
    task automatic t_inherent();
        run(OAG_M_INH, 1'b0, 8'h00, 8'h9a, 8'h11, 8'h22, 0, 1'b0, 1'b1);
        check({14'h0, INT_MASK}, {14'h0, OAG_MASK_LOWERED});
        run(OAG_M_INH, 1'b0, 8'h00, 8'h9b, 8'h11, 8'h22, 0, 1'b1, 1'b0);
        check({14'h0, INT_MASK}, {14'h0, OAG_MASK_RAISED});
    endtask

    // Immediate value and both direct forms, the long one against a slow memory.
    task automatic t_direct();
        run(OAG_M_IMM, 1'b0, 8'h00, 8'ha6, 8'ha5, 8'h5a, 1, 1'b0, 1'b0);
        check({8'h0, OPERAND}, 16'h00a5);
        run(OAG_M_DIR_S, 1'b0, 8'h00, 8'hb6, 8'hc3, 8'h5a, 1, 1'b0, 1'b0);
        check(EA, 16'h00c3);
        wait_q <= 4'h2;
        run(OAG_M_DIR_L, 1'b0, 8'h00, 8'hc6, 8'h12, 8'h34, 2, 1'b0, 1'b0);
        check(EA, 16'h1234);
        wait_q <= 4'h0;
    endtask

    // Indexed forms at the top of the no-offset and short ranges, a low-byte carry in the long one, and the Y swap prefix.
    task automatic t_indexed();
        run(OAG_M_IDX_0, 1'b0, 8'h00, 8'hf6, 8'h33, 8'h44, 0, 1'b0, 1'b0);
        check(EA, 16'h00ff);
        run(OAG_M_IDX_0, 1'b0, OAG_PFX_ALT_INDEX, 8'hf6, 8'h33, 8'h44, 0, 1'b0, 1'b0);
        check(EA, 16'h0040);
        run(OAG_M_IDX_S, 1'b0, 8'h00, 8'he6, 8'hff, 8'h44, 1, 1'b0, 1'b0);
        check(EA, 16'h01fe);
        run(OAG_M_IDX_L, 1'b0, 8'h00, 8'hd6, 8'h12, 8'hf0, 2, 1'b0, 1'b0);
        check(EA, 16'h13ef);
    endtask

    // Page-zero pointers: byte, word with high byte first, and the indirect prefix.
    task automatic t_indirect();
        u_oag_mem_model.mem[16'h0080] = 8'h77;
        u_oag_mem_model.mem[16'h0090] = 8'hab;
        u_oag_mem_model.mem[16'h0091] = 8'hcd;
        run(OAG_M_DIR_S, 1'b1, 8'h00, 8'hb6, 8'h80, 8'h00, 1, 1'b0, 1'b0);
        check(EA, 16'h0077);
        run(OAG_M_DIR_L, 1'b1, 8'h00, 8'hc6, 8'h90, 8'h00, 1, 1'b0, 1'b0);
        check(EA, 16'habcd);
        run(OAG_M_DIR_S, 1'b0, OAG_PFX_INDIRECT, 8'hb6, 8'h80, 8'h00, 1, 1'b0, 1'b0);
        check(EA, 16'h0077);
    endtask

    // Pointer plus index, byte pointer carrying into bit 8 and word pointer.
    task automatic t_ind_indexed();
        u_oag_mem_model.mem[16'h00a0] = 8'hff;
        u_oag_mem_model.mem[16'h00b0] = 8'h12;
        u_oag_mem_model.mem[16'h00b1] = 8'h34;
        run(OAG_M_IDX_S, 1'b1, 8'h00, 8'he6, 8'ha0, 8'h00, 1, 1'b0, 1'b0);
        check(EA, 16'h01fe);
        run(OAG_M_IDX_S, 1'b1, OAG_PFX_ALT_INDIRECT, 8'he6, 8'ha0, 8'h00, 1, 1'b0, 1'b0);
        check(EA, 16'h013f);
        run(OAG_M_IDX_L, 1'b1, 8'h00, 8'hd6, 8'hb0, 8'h00, 1, 1'b0, 1'b0);
        check(EA, 16'h1333);
    endtask

    // Every bit position is taken from the opcode; the byte stays in page zero.
    task automatic t_bit();
        int i;
        for (i = 0; i < 8; i++) begin
            run(OAG_M_BIT, 1'b0, 8'h00, {4'h1, i[2:0], 1'b0}, 8'h9c, 8'h00, 1, 1'b0, 1'b0);
            check({13'h0, BIT_POS}, i[15:0]);
            check(EA, 16'h009c);
        end
        u_oag_mem_model.mem[16'h00c8] = 8'h5c;
        run(OAG_M_BIT, 1'b0, OAG_PFX_INDIRECT, 8'h1e, 8'hc8, 8'h00, 1, 1'b0, 1'b0);
        check({13'h0, BIT_POS}, 16'h0007);
        check(EA, 16'h005c);
    endtask

    // Relative branches: offset after the opcode, then read through a page-zero pointer.
    // The byte count handed to run folds in the signed offset, so PC is judged too.
    task automatic t_relative();
        u_oag_mem_model.mem[16'h00c0] = 8'hfe;
        run(OAG_M_REL, 1'b0, 8'h00, 8'h20, 8'h20, 8'h00, 33, 1'b0, 1'b0);
        check({8'h0, OPERAND}, 16'h0020);
        run(OAG_M_REL, 1'b1, 8'h00, 8'h92, 8'hc0, 8'h00, -1, 1'b0, 1'b0);
        check({8'h0, OPERAND}, 16'h00fe);
    endtask

    // A hang is cut short well above the fewer than two hundred cycles the sequence needs.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    // Main sequence.
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        #1;
        t_reset();
        t_inherent();
        t_direct();
        t_indexed();
        t_indirect();
        t_ind_indexed();
        t_bit();
        t_relative();
        print_verdict();
    end
endmodule
